// ===== hdl/mrhp_pkg.sv
package mrhp_pkg;
  localparam logic [7:0] CMD_READ_ACTUAL_POSITION = 8'h0A;
  localparam logic [7:0] CMD_READ_DESIRED_VELOCITY = 8'h07;
  localparam logic [7:0] CMD_READ_ACTUAL_VELOCITY = 8'h0B;
  localparam logic [7:0] CMD_READ_INTEGRAL_SUM = 8'h0D;
  localparam logic [7:0] CMD_RESET_INTERRUPTS = 8'h1D;
  localparam logic [2:0] LEN_POSITION = 3'h4;
  localparam logic [2:0] LEN_DESIRED_VEL = 3'h4;
  localparam logic [2:0] LEN_ACTUAL_VEL = 3'h2;
  localparam logic [2:0] LEN_INTEGRAL = 3'h2;
  localparam logic [15:0] VEL_MAX = 16'h3FFF;
  localparam logic [15:0] VEL_MIN = 16'hC000;
  localparam int VEL_SHIFT = 16;
  localparam int BUSY_BIT = 0;
  localparam int CMD_ERR_BIT = 1;
  localparam logic [7:0] STATUS_RESET = 8'h00;
  localparam logic [5:0] IRQ_MASK_RESET = 6'h00;
  localparam logic [1:0] BUSY_CYCLES = 2'h2;
  typedef enum logic [1:0] {
    MRHP_IDLE = 2'b00,
    MRHP_LOAD = 2'b01,
    MRHP_SEND = 2'b11
  } mrhp_state_t;
endpackage : mrhp_pkg

// ===== hdl/mrhp_quad_decoder.sv
`timescale 1ns/10ps
module mrhp_quad_decoder (
  input wire logic i_clock,
  input wire logic i_rst,
  input wire logic i_phase_a,
  input wire logic i_phase_b,
  input wire logic i_index,
  input wire logic i_arm_index,
  output logic [31:0] o_position,
  output logic o_index_seen
);
  logic [1:0] prev;
  logic index_prev;
  wire [1:0] cur = {i_phase_a, i_phase_b};
  wire [1:0] moved = cur ^ prev;
  // A glitch that returns before the next edge cancels itself.
  wire step_up = (moved == 2'b01 || moved == 2'b10) &&
                 ((prev[1] ^ cur[0]) == 1'b1);
  wire step_dn = (moved == 2'b01 || moved == 2'b10) &&
                 ((prev[1] ^ cur[0]) == 1'b0);
  wire index_fall = index_prev && !i_index;
  // No filter stage: every sampled edge reaches the counter unless both phases change in the same sample.
  always_ff @(posedge i_clock or posedge i_rst) begin
    if (i_rst) begin
      prev <= 2'b00;
      index_prev <= 1'b1;
      o_position <= 32'h00000000;
      o_index_seen <= 1'b0;
    end else begin
      prev <= cur;
      index_prev <= i_index;
      if (step_up) begin
        o_position <= o_position + 32'h00000001;
      end else if (step_dn) begin
        o_position <= o_position - 32'h00000001;
      end
      o_index_seen <= i_arm_index && index_fall;
    end
  end
endmodule : mrhp_quad_decoder

// ===== hdl/mrhp_host_port.sv
`timescale 1ns/10ps
module mrhp_host_port (
  input wire logic i_clock,
  input wire logic i_rst_n,
  input wire logic i_cs_n,
  input wire logic i_port_select,
  input wire logic i_rd_n,
  input wire logic i_wr_n,
  input wire logic [7:0] i_data,
  output logic [7:0] o_data,
  output logic o_data_oe,
  output logic o_host_irq,
  input wire logic i_phase_a,
  input wire logic i_phase_b,
  input wire logic i_index,
  input wire logic [31:0] i_desired_velocity,
  input wire logic [31:0] i_measured_velocity,
  input wire logic [15:0] i_integral_sum,
  input wire logic [5:0] i_irq_event,
  input wire logic [5:0] i_irq_mask,
  input wire logic i_arm_index,
  output logic [31:0] o_actual_position
);
  logic [1:0] rst_sync;
  wire rst = !rst_sync[1];
  logic [1:0] cs_s1, cs_s2, ps_s1, ps_s2, rd_s1, rd_s2, wr_s1, wr_s2;
  logic [7:0] din_s1, din_s2;
  logic [2:0] enc_s1, enc_s2;
  logic [1:0] rd_hist, wr_hist;
  logic [7:0] status;
  logic [31:0] shift;
  logic [2:0] remaining;
  logic [1:0] busy_count;
  logic [7:0] pending_cmd;
  logic [31:0] position;
  logic index_seen;
  mrhp_pkg::mrhp_state_t state, next_state;

  always_ff @(posedge i_clock or negedge i_rst_n) begin
    if (!i_rst_n) begin
      rst_sync <= 2'b00;
    end else begin
      rst_sync <= {rst_sync[0], 1'b1};
    end
  end

  // Bus pins are asynchronous to the clock and pass two flip-flops.
  always_ff @(posedge i_clock or posedge rst) begin
    if (rst) begin
      cs_s1 <= 2'b11;
      cs_s2 <= 2'b11;
      ps_s1 <= 2'b00;
      ps_s2 <= 2'b00;
      rd_s1 <= 2'b11;
      rd_s2 <= 2'b11;
      wr_s1 <= 2'b11;
      wr_s2 <= 2'b11;
      din_s1 <= 8'h00;
      din_s2 <= 8'h00;
      enc_s1 <= 3'b001;
      enc_s2 <= 3'b001;
    end else begin
      cs_s1 <= {1'b0, i_cs_n};
      cs_s2 <= cs_s1;
      ps_s1 <= {1'b0, i_port_select};
      ps_s2 <= ps_s1;
      rd_s1 <= {1'b0, i_rd_n};
      rd_s2 <= rd_s1;
      wr_s1 <= {1'b0, i_wr_n};
      wr_s2 <= wr_s1;
      din_s1 <= i_data;
      din_s2 <= din_s1;
      enc_s1 <= {i_phase_a, i_phase_b, i_index};
      enc_s2 <= enc_s1;
    end
  end

  mrhp_quad_decoder u_decoder (
    .i_clock(i_clock),
    .i_rst(rst),
    .i_phase_a(enc_s2[2]),
    .i_phase_b(enc_s2[1]),
    .i_index(enc_s2[0]),
    .i_arm_index(i_arm_index),
    .o_position(position),
    .o_index_seen(index_seen)
  );

  wire sel = !cs_s2[0];
  wire rd_active = sel && !rd_s2[0];
  wire wr_active = sel && !wr_s2[0];
  // A transfer is taken when the strobe ends, so the byte shown during
  // the strobe is still the one the host is reading.
  wire rd_end = rd_hist == 2'b10;
  wire wr_end = wr_hist == 2'b10;
  wire busy = status[mrhp_pkg::BUSY_BIT];
  // Port select low is the command port on writes and status on reads.
  wire cmd_write = wr_end && !ps_s2[0] && !busy;
  wire data_write = wr_end && ps_s2[0] && !busy;
  wire data_read = rd_end && ps_s2[0] && !busy;
  wire is_pos = din_s2 == mrhp_pkg::CMD_READ_ACTUAL_POSITION;
  wire is_dvel = din_s2 == mrhp_pkg::CMD_READ_DESIRED_VELOCITY;
  wire is_avel = din_s2 == mrhp_pkg::CMD_READ_ACTUAL_VELOCITY;
  wire is_sum = din_s2 == mrhp_pkg::CMD_READ_INTEGRAL_SUM;
  wire is_rsti = din_s2 == mrhp_pkg::CMD_RESET_INTERRUPTS;
  wire known = is_pos || is_dvel || is_avel || is_sum;

  // Integer part of measured velocity, already at upper-word scale.
  wire [15:0] vel_int = i_measured_velocity[mrhp_pkg::VEL_SHIFT +: 16];
  wire vel_hi = !vel_int[15] && (vel_int > mrhp_pkg::VEL_MAX);
  wire vel_lo = vel_int[15] && (vel_int < mrhp_pkg::VEL_MIN);
  wire [15:0] vel_clamped = vel_hi ? mrhp_pkg::VEL_MAX :
                            vel_lo ? mrhp_pkg::VEL_MIN : vel_int;

  // Readback only samples live values, so motion is never touched.
  wire [31:0] load_value =
    (pending_cmd == mrhp_pkg::CMD_READ_ACTUAL_POSITION) ? position :
    (pending_cmd == mrhp_pkg::CMD_READ_DESIRED_VELOCITY) ?
      i_desired_velocity :
    (pending_cmd == mrhp_pkg::CMD_READ_ACTUAL_VELOCITY) ?
      {vel_clamped, 16'h0000} :
    {i_integral_sum, 16'h0000};
  wire [2:0] load_len =
    (pending_cmd == mrhp_pkg::CMD_READ_ACTUAL_POSITION) ?
      mrhp_pkg::LEN_POSITION :
    (pending_cmd == mrhp_pkg::CMD_READ_DESIRED_VELOCITY) ?
      mrhp_pkg::LEN_DESIRED_VEL :
    (pending_cmd == mrhp_pkg::CMD_READ_ACTUAL_VELOCITY) ?
      mrhp_pkg::LEN_ACTUAL_VEL : mrhp_pkg::LEN_INTEGRAL;

  wire bad_write = data_write && (state == mrhp_pkg::MRHP_SEND);
  wire bad_read = data_read && (state != mrhp_pkg::MRHP_SEND);
  wire cmd_error = bad_write || bad_read;
  wire [5:0] cur_flags = {status[6:3], status[2], status[1]};
  wire [5:0] clear_flags = (cmd_write && is_rsti) ? 6'h3F : 6'h00;
  // Event set wins over a clear in the same cycle.
  wire [5:0] raised = {i_irq_event[5:2],
                       i_irq_event[1] | index_seen,
                       i_irq_event[0] | cmd_error};
  wire [5:0] next_flags = (cur_flags & ~clear_flags) | raised;
  wire next_irq = |(next_flags & i_irq_mask);
  wire [7:0] next_out =
    (rd_active && !ps_s2[0]) ? status : shift[31:24];

  always_comb begin
    next_state = state;
    unique case (state)
      mrhp_pkg::MRHP_IDLE: begin
        if (cmd_write && known) begin
          next_state = mrhp_pkg::MRHP_LOAD;
        end
      end
      mrhp_pkg::MRHP_LOAD: begin
        next_state = mrhp_pkg::MRHP_SEND;
      end
      mrhp_pkg::MRHP_SEND: begin
        if (cmd_write) begin
          next_state = known ? mrhp_pkg::MRHP_LOAD :
                       mrhp_pkg::MRHP_IDLE;
        end else if (data_read && remaining == 3'h1) begin
          next_state = mrhp_pkg::MRHP_IDLE;
        end
      end
      default: begin
        next_state = mrhp_pkg::MRHP_IDLE;
      end
    endcase
  end

  always_ff @(posedge i_clock or posedge rst) begin
    if (rst) begin
      state <= mrhp_pkg::MRHP_IDLE;
      rd_hist <= 2'b00;
      wr_hist <= 2'b00;
      pending_cmd <= 8'h00;
      shift <= 32'h00000000;
      remaining <= 3'h0;
      busy_count <= 2'h0;
      status <= mrhp_pkg::STATUS_RESET;
      o_data <= 8'h00;
      o_data_oe <= 1'b0;
      o_host_irq <= 1'b0;
      o_actual_position <= 32'h00000000;
    end else begin
      state <= next_state;
      rd_hist <= {rd_hist[0], rd_active};
      wr_hist <= {wr_hist[0], wr_active};
      if (cmd_write) begin
        pending_cmd <= din_s2;
      end
      if (state == mrhp_pkg::MRHP_LOAD) begin
        shift <= load_value;
        remaining <= load_len;
      end else if (data_read && state == mrhp_pkg::MRHP_SEND) begin
        shift <= {shift[23:0], 8'h00};
        remaining <= remaining - 3'h1;
      end
      // A brief busy window follows each accepted command or byte.
      if (cmd_write || data_read || data_write) begin
        busy_count <= mrhp_pkg::BUSY_CYCLES;
      end else if (busy_count != 2'h0) begin
        busy_count <= busy_count - 2'h1;
      end
      status[0] <= (cmd_write || data_read || data_write ||
                    busy_count > 2'h1);
      status[6:1] <= next_flags;
      o_data <= next_out;
      o_data_oe <= rd_active;
      o_host_irq <= next_irq;
      o_actual_position <= position;
    end
  end
endmodule : mrhp_host_port

// ===== tb/mrhp_host_port_asserts.sv
`timescale 1ns/10ps
module mrhp_host_port_asserts (
  input wire logic i_clock,
  input wire logic i_rst_n,
  input wire logic i_cs_n,
  input wire logic i_rd_n,
  input wire logic i_wr_n,
  input wire logic o_data_oe,
  input wire logic o_host_irq,
  input wire logic i_phase_a,
  input wire logic i_phase_b,
  input wire logic [5:0] i_irq_mask,
  input wire logic [31:0] o_actual_position
);
  default clocking cb @(posedge i_clock); endclocking
  default disable iff (!i_rst_n);
  // Six quiet cycles cover the pin synchronisers and the counter stage.
  sequence s_quiet;
    ($stable(i_phase_a) && $stable(i_phase_b))[*6];
  endsequence
  sequence s_step;
    s_quiet ##1 ($changed(i_phase_a) != $changed(i_phase_b)) ##1 s_quiet;
  endsequence
  a_irq_masked:
    assert property (o_host_irq |-> |$past(i_irq_mask))
    else $error("irq without mask");
  a_irq_all_masked:
    assert property ((i_irq_mask == 6'h00)[*2] |-> !o_host_irq)
    else $error("irq while masked");
  a_irq_holds:
    assert property ((i_wr_n && $stable(i_irq_mask))[*7] ##0 o_host_irq
      |=> o_host_irq) else $error("irq dropped");
  a_oe_on_read:
    assert property ((!i_rd_n && !i_cs_n)[*6] |-> o_data_oe)
    else $error("no drive on read");
  a_oe_release:
    assert property ($rose(i_rd_n) |-> ##[1:6] !o_data_oe)
    else $error("bus not released");
  a_pos_quiet:
    assert property (s_quiet |-> $stable(o_actual_position))
    else $error("position moved");
  a_pos_unit_step:
    assert property ($changed(o_actual_position) |->
      (o_actual_position - $past(o_actual_position)) inside
      {32'h00000001, 32'hFFFFFFFF}) else $error("position jump");
  a_pos_follows:
    assert property (s_step |->
      o_actual_position != $past(o_actual_position, 7))
    else $error("step lost");
endmodule : mrhp_host_port_asserts

// ===== tb/mrhp_host.sv
`timescale 1ns/10ps
module mrhp_host (
  input wire logic i_clock,
  input wire logic [7:0] i_data,
  output logic o_cs_n,
  output logic o_port_select,
  output logic o_rd_n,
  output logic o_wr_n,
  output logic [7:0] o_data
);
  initial begin
    {o_cs_n, o_rd_n, o_wr_n, o_port_select} = 4'hE;
    o_data = 8'h00;
  end
  // The port has no ready line, so strobes span a fixed, generous time.
  task automatic strobe(input logic wr, input logic ps, input logic [7:0] d,
                        output logic [7:0] q);
    @(negedge i_clock);
    o_cs_n = 1'b0;
    o_port_select = ps;
    o_data = d;
    {o_rd_n, o_wr_n} = {wr, !wr};
    repeat (6) @(negedge i_clock);
    q = i_data;
    {o_rd_n, o_wr_n} = 2'h3;
    @(negedge i_clock);
    o_cs_n = 1'b1;
    repeat (5) @(negedge i_clock);
    o_data = ~d;
  endtask : strobe
  task automatic xfer(input logic wr, input logic ps, input logic [7:0] d,
                      output logic [7:0] q);
    logic [7:0] s;
    s = 8'h01;
    for (int n = 0; n < 8 && s[0]; n++)
      strobe(1'b0, 1'b0, 8'h00, s);
    strobe(wr, ps, d, q);
  endtask : xfer
endmodule : mrhp_host

// ===== tb/tb_top.sv
`timescale 1ns/10ps
module tb_top;
  localparam logic [31:0] CORNER [4] = '{32'h3FFF0000, 32'h40000000,
    32'hC000FFFF, 32'hBFFF0000};
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic pa = 1'b0;
  logic pb = 1'b0;
  logic cs_n, ps, rd_n, wr_n, irq;
  logic [7:0] to_dut, from_dut, b;
  logic [31:0] dvel = 32'h0;
  logic [31:0] mvel = 32'h0;
  logic [15:0] isum = 16'h0;
  logic [5:0] ev = 6'h00;
  logic [5:0] mask = 6'h00;
  logic [31:0] seed = 32'h27;
  logic [31:0] cnt = 32'h0;
  logic [31:0] v;
  int n_errors = 0;
  int checks = 0;
  initial begin
    forever #5 clk = ~clk;
  end
  mrhp_host_port mrhp_host_port_i (.i_clock(clk), .i_rst_n(rst_n),
    .i_cs_n(cs_n), .i_port_select(ps), .i_rd_n(rd_n), .i_wr_n(wr_n),
    .i_data(to_dut), .o_data(from_dut), .o_data_oe(), .o_host_irq(irq),
    .i_phase_a(pa), .i_phase_b(pb), .i_index(1'b1),
    .i_desired_velocity(dvel), .i_measured_velocity(mvel),
    .i_integral_sum(isum), .i_irq_event(ev), .i_irq_mask(mask),
    .i_arm_index(1'b0), .o_actual_position());
  mrhp_host mrhp_host_i (.i_clock(clk), .i_data(from_dut), .o_cs_n(cs_n),
    .o_port_select(ps), .o_rd_n(rd_n), .o_wr_n(wr_n), .o_data(to_dut));
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], 1'b0} ^ (s[31] ? 32'h04C11DB7 : 32'h0);
  endfunction : lfsr
  function automatic logic [31:0] vclamp(input logic [31:0] m);
    if ($signed(m[31:16]) > $signed(mrhp_pkg::VEL_MAX))
      return {16'h0, mrhp_pkg::VEL_MAX};
    if ($signed(m[31:16]) < $signed(mrhp_pkg::VEL_MIN))
      return {16'h0, mrhp_pkg::VEL_MIN};
    return {16'h0, m[31:16]};
  endfunction : vclamp
  task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      n_errors++;
      $display("Error %0t got %h expected %h", $time, got, exp);
    end
  endtask : cmp
  task automatic cmd(input logic [7:0] c);
    mrhp_host_i.xfer(1'b1, 1'b0, c, b);
  endtask : cmd
  task automatic rdback(input logic [7:0] c, input int n);
    cmd(c);
    v = 32'h0;
    for (int k = 0; k < n; k++) begin
      mrhp_host_i.xfer(1'b0, 1'b1, 8'h00, b);
      v = {v[23:0], b};
    end
  endtask : rdback
  // Quadrature steps, then a one-cycle spike that must leave no count.
  task automatic steps(input int n);
    repeat (n) begin
      repeat (8) @(negedge clk);
      {pa, pb} = {pb, ~pa};
      cnt++;
    end
    repeat (8) @(negedge clk);
    pa = ~pa;
    @(negedge clk);
    pa = ~pa;
  endtask : steps
  task automatic final_report();
    if (n_errors == 0 && checks > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask : final_report
  initial begin
    repeat (60000) @(posedge clk);
    n_errors++;
    final_report();
  end
  initial begin
    repeat (6) @(negedge clk);
    rst_n = 1'b1;
    repeat (4) @(negedge clk);
    for (int t = 0; t < 8; t++) begin
      seed = lfsr(seed);
      mvel = (t < 4) ? CORNER[t] : seed;
      dvel = ~seed;
      isum = seed[23:8];
      cmd(mrhp_pkg::CMD_READ_ACTUAL_POSITION);
      mrhp_host_i.xfer(1'b0, 1'b1, 8'h00, b);
      rdback(mrhp_pkg::CMD_READ_ACTUAL_VELOCITY, 2);
      cmp(v, vclamp(mvel));
      fork
        steps(int'(seed[3:0]) + 1);
        rdback(mrhp_pkg::CMD_READ_DESIRED_VELOCITY, 4);
      join
      cmp(v, dvel);
      rdback(mrhp_pkg::CMD_READ_INTEGRAL_SUM, 2);
      cmp(v, {16'h0, isum});
      rdback(mrhp_pkg::CMD_READ_ACTUAL_POSITION, 4);
      cmp(v, cnt);
    end
    for (int k = 0; k < 6; k++) begin
      ev = 6'h01 << k;
      @(negedge clk);
      ev = 6'h00;
      mrhp_host_i.strobe(1'b0, 1'b0, 8'h00, b);
      cmp({24'h0, b}, 32'h2 << k);
      cmp({31'h0, irq}, 32'h0);
      mask = 6'h01 << k;
      repeat (3) @(negedge clk);
      cmp({31'h0, irq}, 32'h1);
      cmd(mrhp_pkg::CMD_RESET_INTERRUPTS);
      cmp({31'h0, irq}, 32'h0);
      mask = 6'h00;
    end
    final_report();
  end
endmodule : tb_top
bind mrhp_host_port mrhp_host_port_asserts mrhp_host_port_asserts_i (
  .i_clock, .i_rst_n, .i_cs_n, .i_rd_n, .i_wr_n, .o_data_oe, .o_host_irq,
  .i_phase_a, .i_phase_b, .i_irq_mask, .o_actual_position);
